// file: scbc_cfg.svh
// Constants of the serial clock select and baud generator block.
// Assumes inclusion by bare name from the package, the checker and the testbench.
`ifndef SCBC_CFG_SVH
`define SCBC_CFG_SVH

// Register indices on the three-bit register port.
`define SCBC_OFF_CLK_MODE     3'h0
`define SCBC_OFF_TC_LOW       3'h1
`define SCBC_OFF_TC_HIGH      3'h2
`define SCBC_OFF_MISC         3'h3
`define SCBC_OFF_STATUS       3'h4

// Clock mode control fields.
`define SCBC_CM_CRYSTAL_OSCILLATOR_BIT      7
`define SCBC_CM_RX_HI         6
`define SCBC_CM_RX_LO         5
`define SCBC_CM_TX_HI         4
`define SCBC_CM_TX_LO         3
`define SCBC_CM_DIR_BIT       2
`define SCBC_CM_OUT_HI        1
`define SCBC_CM_OUT_LO        0

// Miscellaneous control fields kept by this block.
`define SCBC_MISC_SRC_BIT     1
`define SCBC_MISC_EN_BIT      0
`define SCBC_MISC_MASK        8'h03

// Clock select codes shared by receive and transmit, then the pin output source codes.
`define SCBC_SEL_PRIMARY      2'h0
`define SCBC_SEL_BIDIR        2'h1
`define SCBC_SEL_BAUD         2'h2
`define SCBC_SEL_RECOVERED    2'h3
`define SCBC_OUT_OSC          2'h0
`define SCBC_OUT_TXCLK        2'h1
`define SCBC_OUT_BAUD         2'h2
`define SCBC_OUT_RECOVERED    2'h3

// Reset values.
`define SCBC_RST_CLK_MODE     8'h28
`define SCBC_RST_TC_LOW       8'h00
`define SCBC_RST_TC_HIGH      8'h00
`define SCBC_RST_MISC         8'h00

// Timing.
`define SCBC_CLK_HZ           10000000
`define SCBC_OSC_SETTLE_MS    20
`define SCBC_OSC_SETTLE_CYC   ((`SCBC_OSC_SETTLE_MS * `SCBC_CLK_HZ + 999) / 1000)
`define SCBC_EN_SYNC_COUNTS   2

`endif

// file: scbc_pkg.sv
// Types of the serial clock select and baud generator block.
// Assumes the constants header is on the include path.
package scbc_pkg;
`include "scbc_cfg.svh"

    typedef logic [1:0] scbc_sel_t;

    typedef enum logic [1:0]
    {
        SCBC_BG_COUNT  = 2'b01,
        SCBC_BG_RELOAD = 2'b10
    } scbc_bg_e;

endpackage : scbc_pkg

// file: scbc_clock_ctrl.sv
// Clock mode control, clock source multiplexers, bidirectional clock pin
// control and baud generator of one serial channel.
// Assumes pin inputs are asynchronous to core_clk and that the register
// port master is synchronous to core_clk.
//
// Summary of operation
// - Oscillator bit 0 means logic-level clock pin; 1 enables crystal amplifier.
// - In crystal mode internal sync is 0 and oscillator is a clock source.
// - Reset clears the oscillator bit: logic-level input, amplifier off.
// - Receive select: clock pin, bidirectional pin, baud generator, recovered clock.
// - Reset makes the receive clock come from the bidirectional pin.
// - Transmit select: clock pin, bidirectional pin, baud generator, recovered clock.
// - Transmit recovered clock is the 90 degree lagged version.
// - Reset makes the transmit clock come from the bidirectional pin.
// - Direction bit 1 drives bidirectional pin from output source; 0 is input.
// - Pin stays input whenever receive or transmit clock selects it.
// - Reset clears the direction bit, pin becomes input.
// - Output source: oscillator, transmit clock, baud generator, recovered clock.
// - Oscillator chosen for output without crystal mode drives pin high.
// - Recovered clock output on the pin is the receiver version.
// - Reset selects the oscillator as output source.
// - Time constant writes accepted anytime, applied at next counter reload.
// - Counter counts down to zero, one reload cycle, toggles output.
// - Time constant is a separately written low byte and high byte.
// - Enable acts after two counts; disable stops counting at once.
// - Source bit 1 is processor clock, 0 clock pin or oscillator.
`timescale 1ns/1ps

module scbc_clock_ctrl
    import scbc_pkg::*;
#(
    parameter int OSC_SETTLE_CYCLES = `SCBC_OSC_SETTLE_CYC
)
(
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       srst,
    // Register port.
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    output logic      [7:0] regRdData,
    // Clock and sync pins.
    input  wire logic       primaryClockPin,
    input  wire logic       syncPin,
    input  wire logic       crystalOscIn,
    input  wire logic       bidirClockPinIn,
    output logic            bidirClockPinOut,
    output logic            bidirClockPinOeN,
    output logic            crystalAmpEn,
    // Recovered clock circuit outputs.
    input  wire logic       recClkRx,
    input  wire logic       recClkTx,
    // Internal clocks towards the channel.
    output logic            rxClk,
    output logic            txClk,
    output logic            baudOut,
    output logic            syncInternal
);

    // The settle counter is 18 bits wide, so larger counts cannot be served.
    if (OSC_SETTLE_CYCLES < 1 || OSC_SETTLE_CYCLES > 262143)
    begin : g_bad_settle
        $error("OSC_SETTLE_CYCLES must lie in 1 to 262143.");
    end

    localparam int NSYNC = 6;

    // Registers.
    logic [7:0]  clkMode_r;
    logic [7:0]  tcLow_r;
    logic [7:0]  tcHigh_r;
    logic [7:0]  misc_r;
    logic [7:0]  rdData_r;

    // Synchronisers.
    logic [NSYNC-1:0] syncA_r;
    logic [NSYNC-1:0] syncB_r;

    // Baud generator state.
    scbc_bg_e    bgState_r;
    logic [15:0] bgCount_r;
    logic        bgToggle_r;
    logic [1:0]  bgEnPipe_r;
    logic        bgSrcPrev_r;

    // Oscillator settle counter.
    logic [17:0] settleCnt_r;
    logic        oscStable_r;

    // Output flip-flops.
    logic        rxClk_r;
    logic        txClk_r;
    logic        pinOut_r;
    logic        pinOeN_r;
    logic        ampEn_r;
    logic        syncInt_r;

    // Decoded fields.
    wire logic        xtalMode  = clkMode_r[`SCBC_CM_CRYSTAL_OSCILLATOR_BIT];
    wire scbc_sel_t   rxSel     = clkMode_r[`SCBC_CM_RX_HI:`SCBC_CM_RX_LO];
    wire scbc_sel_t   txSel     = clkMode_r[`SCBC_CM_TX_HI:`SCBC_CM_TX_LO];
    wire logic        dirBit    = clkMode_r[`SCBC_CM_DIR_BIT];
    wire scbc_sel_t   outSel    = clkMode_r[`SCBC_CM_OUT_HI:`SCBC_CM_OUT_LO];
    wire logic        bgSrcPclk = misc_r[`SCBC_MISC_SRC_BIT];
    wire logic        bgEnable  = misc_r[`SCBC_MISC_EN_BIT];
    wire logic [15:0] timeConst = {tcHigh_r, tcLow_r};

    // Synchronised pin levels.
    wire logic primSync  = syncB_r[0];
    wire logic sypSync   = syncB_r[1];
    wire logic oscSync   = syncB_r[2];
    wire logic bidirSync = syncB_r[3];
    wire logic recRxSync = syncB_r[4];
    wire logic recTxSync = syncB_r[5];

    // Register port decode.
    wire logic selClkMode = (regAddr == `SCBC_OFF_CLK_MODE);
    wire logic selTcLow   = (regAddr == `SCBC_OFF_TC_LOW);
    wire logic selTcHigh  = (regAddr == `SCBC_OFF_TC_HIGH);
    wire logic selMisc    = (regAddr == `SCBC_OFF_MISC);
    wire logic selStatus  = (regAddr == `SCBC_OFF_STATUS);

    wire logic wrClkMode = regWrEn && selClkMode;
    wire logic wrTcLow   = regWrEn && selTcLow;
    wire logic wrTcHigh  = regWrEn && selTcHigh;
    wire logic wrMisc    = regWrEn && selMisc;

    wire logic [7:0] statusWord =
        {3'h0, bgEnPipe_r[1], oscStable_r, xtalMode, ~pinOeN_r, bgToggle_r};

    logic [7:0] rdMux;
    always_comb
    begin
        rdMux = 8'h00;
        if (selClkMode)
        begin
            rdMux = clkMode_r;
        end
        else if (selTcLow)
        begin
            rdMux = tcLow_r;
        end
        else if (selTcHigh)
        begin
            rdMux = tcHigh_r;
        end
        else if (selMisc)
        begin
            rdMux = misc_r & `SCBC_MISC_MASK;
        end
        else if (selStatus)
        begin
            rdMux = statusWord;
        end
    end

    wire logic [7:0] rdData_nxt = regRdEn ? rdMux : 8'h00;

    // The clock pin carries the oscillator when the crystal is in use.
    wire logic primSource = xtalMode ? oscSync : primSync;

    // Baud generator source and tick.
    wire logic bgSrcLvl = primSource;
    wire logic bgTick   = bgSrcPclk ? 1'b1 : (bgSrcLvl && !bgSrcPrev_r);
    // Gating with the enable itself stops the count in the same cycle as the clear.
    wire logic bgRun    = bgTick && bgEnPipe_r[1] && bgEnable;

    // Enable passes two source counts before the counter runs.
    wire logic [1:0] bgEnPipe_nxt =
        !bgEnable ? 2'b00 :
        bgTick    ? {bgEnPipe_r[0], 1'b1} : bgEnPipe_r;

    // Counting down, then one reload cycle that takes the new constant.
    logic        bgToggle_nxt;
    logic [15:0] bgCount_nxt;
    scbc_bg_e    bgState_nxt;
    always_comb
    begin
        bgToggle_nxt = bgToggle_r;
        bgCount_nxt  = bgCount_r;
        bgState_nxt  = bgState_r;
        if (bgRun)
        begin
            case (bgState_r)
                SCBC_BG_COUNT:
                begin
                    if (bgCount_r == 16'h0000)
                    begin
                        bgState_nxt = SCBC_BG_RELOAD;
                    end
                    else
                    begin
                        bgCount_nxt = bgCount_r - 16'h0001;
                    end
                end
                SCBC_BG_RELOAD:
                begin
                    bgCount_nxt  = timeConst;
                    bgToggle_nxt = ~bgToggle_r;
                    bgState_nxt  = SCBC_BG_COUNT;
                end
                default:
                begin
                    bgState_nxt = SCBC_BG_COUNT;
                end
            endcase
        end
    end

    // Receive and transmit clock multiplexers.
    logic rxClk_nxt;
    logic txClk_nxt;
    always_comb
    begin
        case (rxSel)
            `SCBC_SEL_PRIMARY:   rxClk_nxt = primSource;
            `SCBC_SEL_BIDIR:     rxClk_nxt = bidirSync;
            `SCBC_SEL_BAUD:      rxClk_nxt = bgToggle_r;
            default:             rxClk_nxt = recRxSync;
        endcase
        case (txSel)
            `SCBC_SEL_PRIMARY:   txClk_nxt = primSource;
            `SCBC_SEL_BIDIR:     txClk_nxt = bidirSync;
            `SCBC_SEL_BAUD:      txClk_nxt = bgToggle_r;
            default:             txClk_nxt = recTxSync;
        endcase
    end

    // Bidirectional pin direction and output source.
    wire logic pinTaken  = (rxSel == `SCBC_SEL_BIDIR) || (txSel == `SCBC_SEL_BIDIR);
    wire logic pinDrive  = dirBit && !pinTaken;

    logic pinOut_nxt;
    always_comb
    begin
        case (outSel)
            `SCBC_OUT_OSC:       pinOut_nxt = xtalMode ? oscSync : 1'b1;
            `SCBC_OUT_TXCLK:     pinOut_nxt = txClk_r;
            `SCBC_OUT_BAUD:      pinOut_nxt = bgToggle_r;
            default:             pinOut_nxt = recRxSync;
        endcase
    end

    // Oscillator settle counter, restarted whenever crystal mode is off.
    wire logic settleDone = (settleCnt_r == 18'(OSC_SETTLE_CYCLES - 1));
    wire logic [17:0] settleCnt_nxt =
        !xtalMode  ? 18'h00000 :
        settleDone ? settleCnt_r : settleCnt_r + 18'h00001;
    wire logic oscStable_nxt = xtalMode && (settleDone || oscStable_r);

    // Synchronisers for every pin input.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            syncA_r <= '0;
            syncB_r <= '0;
        end
        else
        begin
            syncA_r <= {recClkTx, recClkRx, bidirClockPinIn,
                        crystalOscIn, syncPin, primaryClockPin};
            syncB_r <= syncA_r;
        end
    end

    // Register file.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            clkMode_r <= `SCBC_RST_CLK_MODE;
            tcLow_r   <= `SCBC_RST_TC_LOW;
            tcHigh_r  <= `SCBC_RST_TC_HIGH;
            misc_r    <= `SCBC_RST_MISC;
            rdData_r  <= 8'h00;
        end
        else
        begin
            if (wrClkMode)
            begin
                clkMode_r <= regWrData;
            end
            if (wrTcLow)
            begin
                tcLow_r <= regWrData;
            end
            if (wrTcHigh)
            begin
                tcHigh_r <= regWrData;
            end
            if (wrMisc)
            begin
                misc_r <= regWrData & `SCBC_MISC_MASK;
            end
            rdData_r <= rdData_nxt;
        end
    end

    // Baud generator.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            bgState_r   <= SCBC_BG_COUNT;
            bgCount_r   <= 16'h0000;
            bgToggle_r  <= 1'b0;
            bgEnPipe_r  <= 2'b00;
            bgSrcPrev_r <= 1'b0;
        end
        else
        begin
            bgState_r   <= bgState_nxt;
            bgCount_r   <= bgCount_nxt;
            bgToggle_r  <= bgToggle_nxt;
            bgEnPipe_r  <= bgEnPipe_nxt;
            bgSrcPrev_r <= bgSrcLvl;
        end
    end

    // Settle counter.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            settleCnt_r <= 18'h00000;
            oscStable_r <= 1'b0;
        end
        else
        begin
            settleCnt_r <= settleCnt_nxt;
            oscStable_r <= oscStable_nxt;
        end
    end

    // Output flip-flops.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            rxClk_r   <= 1'b0;
            txClk_r   <= 1'b0;
            pinOut_r  <= 1'b0;
            pinOeN_r  <= 1'b1;
            ampEn_r   <= 1'b0;
            syncInt_r <= 1'b0;
        end
        else
        begin
            rxClk_r   <= rxClk_nxt;
            txClk_r   <= txClk_nxt;
            pinOut_r  <= pinDrive ? pinOut_nxt : 1'b0;
            pinOeN_r  <= ~pinDrive;
            ampEn_r   <= xtalMode;
            syncInt_r <= xtalMode ? 1'b0 : sypSync;
        end
    end

    assign regRdData        = rdData_r;
    assign rxClk            = rxClk_r;
    assign txClk            = txClk_r;
    assign baudOut          = bgToggle_r;
    assign bidirClockPinOut = pinOut_r;
    assign bidirClockPinOeN = pinOeN_r;
    assign crystalAmpEn     = ampEn_r;
    assign syncInternal     = syncInt_r;

endmodule : scbc_clock_ctrl

// file: scbc_clock_ctrl_asserts.sv
// Port-level assertions for the clock select and baud generator block.
// Assumes one clock, core_clk, and the synchronous active-high reset srst.
`timescale 1ns/1ps
`include "scbc_cfg.svh"

module scbc_clock_ctrl_asserts
(
    // Clock and reset.
    input wire logic       core_clk,
    input wire logic       srst,
    // Register port.
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrEn,
    // Pin and clock outputs.
    input wire logic       bidirClockPinOut,
    input wire logic       bidirClockPinOeN,
    input wire logic       crystalAmpEn,
    input wire logic       baudOut,
    input wire logic       syncInternal
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    wire logic modeWr   = regWrEn && (regAddr == `SCBC_OFF_CLK_MODE);
    wire logic miscWr   = regWrEn && (regAddr == `SCBC_OFF_MISC);
    wire logic bidirSel = (regWrData[6:5] == `SCBC_SEL_BIDIR) || (regWrData[4:3] == `SCBC_SEL_BIDIR);
    wire logic driveWr  = modeWr && regWrData[`SCBC_CM_DIR_BIT] && !bidirSel;

    sequence s_stop_wr;
        miscWr && !regWrData[`SCBC_MISC_EN_BIT];
    endsequence
    sequence s_start_wr;
        miscWr && (regWrData[1:0] == 2'h3);
    endsequence
    sequence s_hold6;
        $stable(baudOut) [*6];
    endsequence

    property p_amp_bit;
        modeWr |-> ##2 (crystalAmpEn == $past(regWrData[7], 2));
    endproperty
    property p_reset_state;
        $fell(srst) |-> !crystalAmpEn && bidirClockPinOeN && !baudOut;
    endproperty
    property p_sync_crystal_oscillator;
        crystalAmpEn && $past(crystalAmpEn) |-> !syncInternal;
    endproperty
    property p_pin_in;
        modeWr && bidirSel |-> ##2 bidirClockPinOeN;
    endproperty
    property p_pin_drive;
        driveWr |-> ##2 !bidirClockPinOeN;
    endproperty
    property p_pin_quiet;
        bidirClockPinOeN |-> !bidirClockPinOut;
    endproperty
    property p_osc_high;
        driveWr && (regWrData[1:0] == `SCBC_OUT_OSC) && !regWrData[7] |-> ##2 bidirClockPinOut;
    endproperty
    property p_baud_stop;
        s_stop_wr |-> ##2 s_hold6;
    endproperty
    property p_baud_start;
        s_start_wr |=> $stable(baudOut) [*2];
    endproperty

    a_amp_bit: assert property (p_amp_bit) else $error("amplifier enable wrong");
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
    a_sync_crystal_oscillator: assert property (p_sync_crystal_oscillator) else $error("sync not zero");
    a_pin_in: assert property (p_pin_in) else $error("pin driven while selected");
    a_pin_drive: assert property (p_pin_drive) else $error("pin not driven");
    a_pin_quiet: assert property (p_pin_quiet) else $error("pin value while input");
    a_osc_high: assert property (p_osc_high) else $error("pin not high");
    a_baud_stop: assert property (p_baud_stop) else $error("baud kept running");
    a_baud_start: assert property (p_baud_start) else $error("baud started early");
endmodule : scbc_clock_ctrl_asserts

// file: scbc_tb_top.sv
// Self-checking testbench of the clock select and baud generator block.
// Assumes the header, package, design module and checker are compiled first.
`timescale 1ns/1ps
`include "scbc_cfg.svh"

module tb_top;
    localparam int SETTLE = 10;
    logic       core_clk;
    logic       srst;
    logic [2:0] regAddr;
    logic [7:0] regWrData;
    logic       regWrEn;
    logic       regRdEn;
    logic [7:0] regRdData;
    logic       primaryClockPin;
    logic       syncPin;
    logic       crystalOscIn;
    logic       bidirClockPinIn;
    logic       bidirClockPinOut;
    logic       bidirClockPinOeN;
    logic       crystalAmpEn;
    logic       recClkRx;
    logic       recClkTx;
    logic       rxClk;
    logic       txClk;
    logic       baudOut;
    logic       syncInternal;
    int         err_total;
    int         checks_done;

    scbc_clock_ctrl #(.OSC_SETTLE_CYCLES(SETTLE)) DUT
    (
        .core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .primaryClockPin(primaryClockPin), .syncPin(syncPin), .crystalOscIn(crystalOscIn),
        .bidirClockPinIn(bidirClockPinIn), .bidirClockPinOut(bidirClockPinOut),
        .bidirClockPinOeN(bidirClockPinOeN), .crystalAmpEn(crystalAmpEn),
        .recClkRx(recClkRx), .recClkTx(recClkTx), .rxClk(rxClk), .txClk(txClk),
        .baudOut(baudOut), .syncInternal(syncInternal)
    );

    always #50 core_clk = ~core_clk;

    task automatic wrap_up();
        $display("Checks: %0d, mismatches: %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        regAddr   <= a;
        regWrData <= d;
        regWrEn   <= 1'b1;
        @(posedge core_clk);
        regWrEn <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        @(negedge core_clk);
        d = regRdData;
        @(posedge core_clk);
    endtask : rd

    task automatic src(input logic p, input logic b, input logic rr, input logic rt, input logic o);
        primaryClockPin <= p;
        bidirClockPinIn <= b;
        recClkRx        <= rr;
        recClkTx        <= rt;
        crystalOscIn    <= o;
        repeat (5) @(posedge core_clk);
    endtask : src

    function automatic logic [7:0] mode(input logic x, input logic [1:0] r, input logic [1:0] t,
                                        input logic d, input logic [1:0] o);
        return {x, r, t, d, o};
    endfunction : mode

    // Measures one half period of the baud output, in core clock cycles.
    task automatic meas(output int n);
        logic b;
        n = 0;
        b = baudOut;
        while (baudOut === b && n < 600)
        begin
            @(posedge core_clk);
            n++;
        end
        b = baudOut;
        n = 0;
        while (baudOut === b && n < 600)
        begin
            @(posedge core_clk);
            n++;
        end
    endtask : meas

    task automatic t_reset();
        logic [7:0] d;
        src(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        chk("amp enable", 1'b0, crystalAmpEn);
        chk("pin enable", 1'b1, bidirClockPinOeN);
        chk("rx from pin", 1'b1, rxClk);
        chk("tx from pin", 1'b1, txClk);
        rd(`SCBC_OFF_CLK_MODE, d);
        chk("mode reset", `SCBC_RST_CLK_MODE, d);
    endtask : t_reset

    task automatic t_sel();
        logic [1:0] c;
        logic       l;
        for (int i = 0; i < 8; i++)
        begin
            c = i[2:1];
            l = i[0];
            wr(`SCBC_OFF_CLK_MODE, mode(1'b0, c, c, 1'b0, 2'h0));
            src((c == 2'h0) ? l : !l, (c == 2'h1) ? l : !l, (c == 2'h3) ? l : !l,
                (c == 2'h3) ? l : !l, !l);
            chk("rx select", (c == 2'h2) ? 1'b0 : l, rxClk);
            chk("tx select", (c == 2'h2) ? 1'b0 : l, txClk);
        end
        wr(`SCBC_OFF_CLK_MODE, mode(1'b0, 2'h3, 2'h3, 1'b1, `SCBC_OUT_RECOVERED));
        src(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        chk("rx recovered", 1'b1, rxClk);
        chk("tx lagged", 1'b0, txClk);
        chk("pin recovered", 1'b1, bidirClockPinOut);
    endtask : t_sel

    task automatic t_pin();
        src(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        for (int o = 0; o < 4; o++)
        begin
            wr(`SCBC_OFF_CLK_MODE, mode(1'b0, 2'h0, 2'h0, 1'b1, o[1:0]));
            repeat (4) @(posedge core_clk);
            chk("pin source", (o == 2) ? 1'b0 : 1'b1, bidirClockPinOut);
            chk("pin driven", 1'b0, bidirClockPinOeN);
        end
        wr(`SCBC_OFF_CLK_MODE, mode(1'b0, 2'h0, 2'h0, 1'b0, 2'h0));
        repeat (4) @(posedge core_clk);
        chk("pin input", 1'b1, bidirClockPinOeN);
        for (int k = 0; k < 2; k++)
        begin
            wr(`SCBC_OFF_CLK_MODE, mode(1'b0, k[0] ? 2'h0 : 2'h1, k[0] ? 2'h1 : 2'h0, 1'b1, 2'h2));
            repeat (4) @(posedge core_clk);
            chk("pin kept input", 1'b1, bidirClockPinOeN);
        end
    endtask : t_pin

    task automatic t_crystal_oscillator();
        logic [7:0] d;
        syncPin <= 1'b1;
        wr(`SCBC_OFF_CLK_MODE, mode(1'b0, 2'h0, 2'h0, 1'b0, 2'h0));
        src(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("sync follows pin", 1'b1, syncInternal);
        wr(`SCBC_OFF_CLK_MODE, mode(1'b1, 2'h0, 2'h0, 1'b1, `SCBC_OUT_OSC));
        rd(`SCBC_OFF_STATUS, d);
        chk("amp on", 1'b1, crystalAmpEn);
        chk("crystal status", 1'b1, d[2]);
        chk("sync forced", 1'b0, syncInternal);
        repeat (SETTLE + 4) @(posedge core_clk);
        rd(`SCBC_OFF_STATUS, d);
        chk("osc settled", 1'b1, d[3]);
        for (int v = 1; v >= 0; v--)
        begin
            src(1'b0, 1'b0, 1'b0, 1'b0, v[0]);
            chk("rx from osc", v[0], rxClk);
            chk("pin from osc", v[0], bidirClockPinOut);
        end
        wr(`SCBC_OFF_CLK_MODE, mode(1'b0, 2'h0, 2'h0, 1'b0, 2'h0));
    endtask : t_crystal_oscillator

    task automatic t_baud();
        logic b;
        int   n;
        wr(`SCBC_OFF_TC_LOW, 8'h03);
        wr(`SCBC_OFF_TC_HIGH, 8'h00);
        primaryClockPin <= 1'b0;
        wr(`SCBC_OFF_MISC, 8'h01);
        b = baudOut;
        repeat (40) @(posedge core_clk);
        chk("no pin ticks", b, baudOut);
        n = 0;
        repeat (50)
        begin
            primaryClockPin <= 1'b1;
            repeat (2) @(posedge core_clk);
            primaryClockPin <= 1'b0;
            repeat (2) @(posedge core_clk);
            if (baudOut !== b)
                n++;
            b = baudOut;
        end
        chk("pin ticks", 1'b1, n >= 8 && n <= 10);
        wr(`SCBC_OFF_MISC, 8'h00);
        repeat (10) @(posedge core_clk);
        wr(`SCBC_OFF_MISC, 8'h03);
        meas(n);
        meas(n);
        chk("half period", 16'd5, n[15:0]);
        wr(`SCBC_OFF_TC_LOW, 8'h00);
        wr(`SCBC_OFF_TC_HIGH, 8'h01);
        repeat (3) meas(n);
        chk("new half period", 16'd258, n[15:0]);
        wr(`SCBC_OFF_MISC, 8'h02);
        repeat (3) @(posedge core_clk);
        b = baudOut;
        repeat (20) @(posedge core_clk);
        chk("stopped", b, baudOut);
    endtask : t_baud

    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        wrap_up();
    end

    initial
    begin
        core_clk        = 1'b0;
        srst            = 1'b1;
        regAddr         = 3'h0;
        regWrData       = 8'h00;
        regWrEn         = 1'b0;
        regRdEn         = 1'b0;
        primaryClockPin = 1'b0;
        syncPin         = 1'b0;
        crystalOscIn    = 1'b0;
        bidirClockPinIn = 1'b0;
        recClkRx        = 1'b0;
        recClkTx        = 1'b0;
        err_total       = 0;
        checks_done     = 0;
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_sel();
        t_pin();
        t_crystal_oscillator();
        t_baud();
        wrap_up();
    end
endmodule : tb_top

bind scbc_clock_ctrl scbc_clock_ctrl_asserts u_chk
(
    .core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .bidirClockPinOut(bidirClockPinOut),
    .bidirClockPinOeN(bidirClockPinOeN), .crystalAmpEn(crystalAmpEn),
    .baudOut(baudOut), .syncInternal(syncInternal)
);
